// file: ixs_pkg.sv
// Purpose: Shared constants and types for the index decode and stack select block
// Assumes: 32-bit Wishbone data, byte addresses, each register one aligned word
// Notes:   Stack memory is 16 bits wide; one slot per even byte address
package ixs_pkg;

  // Clock rate, for reference by the bench
  localparam int unsigned CLK_HZ = 25_000_000;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;  // Status word, holds privilege bit
  localparam logic [7:0] OFS_EXT     = 8'h04;  // Brief extension word
  localparam logic [7:0] OFS_BASE    = 8'h08;  // Base address for the EA sum
  localparam logic [7:0] OFS_EA      = 8'h0C;  // Effective address, read only
  localparam logic [7:0] OFS_FIELDS  = 8'h10;  // Decoded fields, read only
  localparam logic [7:0] OFS_INDEX   = 8'h14;  // Scaled index, read only
  localparam logic [7:0] OFS_PRIV_SP = 8'h18;  // Privileged stack pointer
  localparam logic [7:0] OFS_UPRV_SP = 8'h1C;  // Unprivileged stack pointer
  localparam logic [7:0] OFS_ACT_SP  = 8'h20;  // Active stack pointer
  localparam logic [7:0] OFS_CMD     = 8'h24;  // Stack command / busy
  localparam logic [7:0] OFS_OPERAND = 8'h28;  // Operand in, popped result out
  localparam logic [7:0] OFS_PC      = 8'h2C;  // Program counter
  localparam logic [7:0] OFS_DREG    = 8'h40;  // Data registers 0..7
  localparam logic [7:0] OFS_AREG    = 8'h60;  // Address registers 0..7
  localparam logic [7:0] BANK_MASK   = 8'hE0;

  // Brief extension word layout
  localparam int EXT_KIND  = 15;
  localparam int EXT_NUM_H = 14;
  localparam int EXT_NUM_L = 12;
  localparam int EXT_SIZE  = 11;
  localparam int EXT_SCL_H = 10;
  localparam int EXT_SCL_L = 9;
  localparam int EXT_ZERO  = 8;
  localparam int EXT_DSP_H = 7;

  // Status word
  localparam int          SW_PRIV  = 13;
  localparam logic [15:0] SW_RESET = 16'h2000;  // Supervisor after reset

  localparam logic [2:0]  SP_NUM     = 3'h7;
  localparam logic [31:0] BYTES_WORD = 32'h0000_0002;
  localparam logic [31:0] BYTES_LONG = 32'h0000_0004;
  localparam logic [31:0] BYTES_TRAP = 32'h0000_0006;
  localparam logic [1:0]  LANES_ALL  = 2'h3;
  localparam logic [1:0]  LANES_HIGH = 2'h2;

  // Stack commands written to OFS_CMD
  typedef enum logic [3:0] {
    OP_PUSH_B = 4'h0,
    OP_PUSH_W = 4'h1,
    OP_PUSH_L = 4'h2,
    OP_POP_B  = 4'h3,
    OP_POP_W  = 4'h4,
    OP_POP_L  = 4'h5,
    OP_CALL   = 4'h6,
    OP_RET    = 4'h7,
    OP_TRAP   = 4'h8
  } ixs_op_t;

  // Decoded brief extension word
  typedef struct packed {
    logic       kind_addr;
    logic [2:0] num;
    logic       size_long;
    logic [1:0] scale;
    logic       zero_bad;
    logic [7:0] disp;
  } ixs_ext_t;

  // Word request to the stack memory
  typedef struct packed {
    logic        en;
    logic        we;
    logic [31:0] addr;
    logic [15:0] wdata;
    logic [1:0]  lanes;
  } ixs_mem_req_t;

endpackage

// file: ixs_stack_mem.sv
// Purpose: Word-wide stack memory with high and low byte lanes
// Assumes: Byte address in, bit 0 ignored; address wraps modulo the depth
// Notes:   Read data is registered, so it appears one cycle after the request
`timescale 1ns/1ps
module ixs_stack_mem #(
  parameter int AW = 10                  // Word address bits
) (
  input  wire logic                 ref_clk, // Clock
  input  wire ixs_pkg::ixs_mem_req_t req,    // Word request
  output logic [15:0]               rdata    // Registered read data
);

  initial begin
    if (AW < 2 || AW > 24) begin
      $error("ixs_stack_mem: AW out of range");
    end
  end

  logic [15:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] widx;

  assign widx = req.addr[AW:1];

  // Lanes let a byte touch only the high half of a slot
  always_ff @(posedge ref_clk) begin
    if (req.en && req.we && req.lanes[1]) begin
      mem[widx][15:8] <= req.wdata[15:8];
    end
    if (req.en && req.we && req.lanes[0]) begin
      mem[widx][7:0] <= req.wdata[7:0];
    end
    if (req.en && !req.we) begin
      rdata <= mem[widx];
    end
  end

endmodule

// file: ixs_decode_stack.sv
// Purpose: Brief index extension decode, EA sum, and system stack engine
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset
// Notes:   Unmapped offsets ack with zero data; stack commands run one at a time
//
// Function
// [RQ1] Kind bit: clear data, set address register
// [RQ2] Size bit: clear word, set full long
// [RQ3] Word index is sign-extended to 32 bits
// [RQ4] Multiplier codes 00..11 mean 1,2,4,8
// [RQ5] Scale shifts a copy; register stays intact
// [RQ6] Scaling adds no time to EA
// [RQ7] Extension word field positions fixed
// [RQ8] Address register seven is stack pointer
// [RQ9] Supervisor: seven is privileged pointer only
// [RQ10] User: seven is unprivileged pointer only
// [RQ11] System stacks grow toward lower addresses
// [RQ12] Predecrement pushes, postincrement pulls
// [RQ13] Predecrement adjusts before the access
// [RQ14] Postincrement adjusts after the access
// [RQ15] Call pushes PC; return pulls it back
// [RQ16] Traps push PC and status privileged
// [RQ17] Stack adjustments keep word alignment
// [RQ18] Stack bytes use high half only
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
module ixs_decode_stack #(
  parameter int MEM_AW = 10                       // Stack memory word address bits
) (
  input  wire logic        ref_clk,               // 25 MHz clock
  input  wire logic        srst,                  // Synchronous reset, high
  input  wire logic        wb_cyc_i,              // Bus cycle
  input  wire logic        wb_stb_i,              // Strobe
  input  wire logic        wb_we_i,               // Write enable
  input  wire logic [7:0]  wb_adr_i,              // Byte address
  input  wire logic [3:0]  wb_sel_i,              // Byte selects
  input  wire logic [31:0] wb_dat_i,              // Write data
  output logic      [31:0] wb_dat_o,              // Read data, registered
  output logic             wb_ack_o,              // Acknowledge, registered
  output logic             engine_busy,           // Stack command in progress
  output logic             supervisor             // Privilege state bit
);

  // Depth check; the address slice needs a sane memory size
  initial begin
    if (MEM_AW < 2 || MEM_AW > 24) $error("ixs_decode_stack: MEM_AW out of range");
  end
  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_POP_REQ, ST_POP_DATA} ixs_state_t;

  // Architectural and engine state
  logic [31:0] dreg [0:7];
  logic [31:0] areg [0:6];
  logic [31:0] next_dreg [0:7];
  logic [31:0] next_areg [0:6];
  logic [15:0] status_word, next_status_word;
  logic [15:0] ext_word, next_ext_word;
  logic [31:0] base, next_base;
  logic [31:0] privileged_stack_pointer, next_privileged_stack_pointer;
  logic [31:0] unprivileged_stack_pointer, next_unprivileged_stack_pointer;
  logic [31:0] pc, next_pc;
  logic [31:0] operand, next_operand;
  logic [31:0] result, next_result;
  logic [31:0] ea, next_ea;
  logic [31:0] index_scaled, next_index_scaled;
  ixs_state_t  state, next_state;
  ixs_pkg::ixs_op_t op, next_op;
  logic [1:0]  words_left, next_words_left;
  logic [31:0] cur_addr, next_cur_addr;
  logic [47:0] wbuf, next_wbuf;
  logic [31:0] rbuf, next_rbuf;
  logic        use_priv, next_use_priv;
  logic        next_engine_busy, next_wb_ack_o;
  logic [31:0] next_wb_dat_o;
  ixs_pkg::ixs_mem_req_t mem_req;
  logic [15:0] mem_rdata;
  ixs_pkg::ixs_ext_t ext;
  logic [31:0] active_stack_pointer;
  logic [31:0] idx_raw, idx_val;
  logic        take, wr;

  // Byte-lane merge of a bus write into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Sign extension of a word to 32 bits
  function automatic logic [31:0] sext16(input logic [15:0] w);
    return {{16{w[15]}}, w};
  endfunction

  // Bytes a command moves on the stack, always whole words
  function automatic logic [31:0] op_bytes(input ixs_pkg::ixs_op_t o);
    unique case (o)
      ixs_pkg::OP_PUSH_L, ixs_pkg::OP_POP_L,
      ixs_pkg::OP_CALL, ixs_pkg::OP_RET:     return ixs_pkg::BYTES_LONG;
      ixs_pkg::OP_TRAP:                      return ixs_pkg::BYTES_TRAP;
      default:                               return ixs_pkg::BYTES_WORD; // RQ17
    endcase
  endfunction

  // Field split of the brief extension word
  assign ext.kind_addr = ext_word[ixs_pkg::EXT_KIND];                         // RQ7
  assign ext.num       = ext_word[ixs_pkg::EXT_NUM_H:ixs_pkg::EXT_NUM_L];     // RQ7
  assign ext.size_long = ext_word[ixs_pkg::EXT_SIZE];                         // RQ7
  assign ext.scale     = ext_word[ixs_pkg::EXT_SCL_H:ixs_pkg::EXT_SCL_L];     // RQ7
  assign ext.zero_bad  = ext_word[ixs_pkg::EXT_ZERO];                         // RQ7
  assign ext.disp      = ext_word[ixs_pkg::EXT_DSP_H:0];                      // RQ7
  assign supervisor = status_word[ixs_pkg::SW_PRIV];
  // Register seven resolves to one pointer; the other is unreachable as An
  assign active_stack_pointer = supervisor ? privileged_stack_pointer   // RQ8 RQ9
                                           : unprivileged_stack_pointer; // RQ10

  // Index selection, size and scale; only a copy is shifted
  always_comb begin
    if (ext.kind_addr) begin                                            // RQ1
      idx_raw = (ext.num == ixs_pkg::SP_NUM) ? active_stack_pointer : areg[ext.num]; // RQ8
    end else begin
      idx_raw = dreg[ext.num];                                          // RQ1
    end
    idx_val = ext.size_long ? idx_raw : sext16(idx_raw[15:0]);          // RQ2 RQ3
  end

  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o &&
                !(wb_we_i && wb_adr_i == ixs_pkg::OFS_CMD && state != ST_IDLE);
  assign wr   = take && wb_we_i;

  // Next state of registers and stack engine
  always_comb begin
    logic [31:0] sp_now;
    logic [31:0] sp_new;
    logic [31:0] pulled;
    ixs_pkg::ixs_op_t cmd;
    sp_now = 32'h0000_0000;
    sp_new = 32'h0000_0000;
    pulled = 32'h0000_0000;
    cmd    = ixs_pkg::ixs_op_t'(wb_dat_i[3:0]);
    next_dreg = dreg;
    next_areg = areg;
    next_privileged_stack_pointer = privileged_stack_pointer;
    next_unprivileged_stack_pointer = unprivileged_stack_pointer;
    {next_status_word, next_ext_word, next_base, next_pc} = {status_word, ext_word, base, pc};
    {next_operand, next_result, next_cur_addr} = {operand, result, cur_addr};
    {next_wbuf, next_rbuf, next_words_left, next_use_priv} = {wbuf, rbuf, words_left, use_priv};
    next_state = state;
    next_op = op;
    mem_req = '0;
    // Shifting by scale costs no extra cycle: EA is registered every clock
    next_index_scaled = idx_val << ext.scale;                           // RQ4 RQ5 RQ6
    next_ea = base + sext16({{8{ext.disp[7]}}, ext.disp}) + next_index_scaled; // RQ6

    // Software writes
    if (wr) begin
      unique case (wb_adr_i)
        ixs_pkg::OFS_STATUS:  next_status_word = 16'(merge({16'h0000, status_word},
                                                           wb_dat_i, wb_sel_i));
        ixs_pkg::OFS_EXT:     next_ext_word = 16'(merge({16'h0000, ext_word},
                                                        wb_dat_i, wb_sel_i));
        ixs_pkg::OFS_BASE:    next_base = merge(base, wb_dat_i, wb_sel_i);
        ixs_pkg::OFS_PRIV_SP: next_privileged_stack_pointer =
                                merge(privileged_stack_pointer, wb_dat_i, wb_sel_i);
        ixs_pkg::OFS_UPRV_SP: next_unprivileged_stack_pointer =
                                merge(unprivileged_stack_pointer, wb_dat_i, wb_sel_i);
        ixs_pkg::OFS_OPERAND: next_operand = merge(operand, wb_dat_i, wb_sel_i);
        ixs_pkg::OFS_PC:      next_pc = merge(pc, wb_dat_i, wb_sel_i);
        default: begin
          if ((wb_adr_i & ixs_pkg::BANK_MASK) == ixs_pkg::OFS_DREG) begin
            next_dreg[wb_adr_i[4:2]] = merge(dreg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
          end else if ((wb_adr_i & ixs_pkg::BANK_MASK) == ixs_pkg::OFS_AREG) begin
            if (wb_adr_i[4:2] != ixs_pkg::SP_NUM) begin
              next_areg[wb_adr_i[4:2]] = merge(areg[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
            end else if (supervisor) begin                              // RQ9
              next_privileged_stack_pointer =
                merge(privileged_stack_pointer, wb_dat_i, wb_sel_i);
            end else begin                                              // RQ10
              next_unprivileged_stack_pointer =
                merge(unprivileged_stack_pointer, wb_dat_i, wb_sel_i);
            end
          end
        end
      endcase
      if (wb_adr_i == ixs_pkg::OFS_ACT_SP) begin
        if (supervisor) next_privileged_stack_pointer = wb_dat_i;
        else            next_unprivileged_stack_pointer = wb_dat_i;
      end
    end

    // Stack engine; its pointer updates override a same-cycle bus write
    unique case (state)
      ST_IDLE: begin
        if (wr && wb_adr_i == ixs_pkg::OFS_CMD && cmd <= ixs_pkg::OP_TRAP) begin
          next_op = cmd;
          next_use_priv = supervisor || cmd == ixs_pkg::OP_TRAP;        // RQ16
          sp_now = next_use_priv ? privileged_stack_pointer : unprivileged_stack_pointer;
          next_words_left = 2'(op_bytes(cmd) >> 1) - 2'h1;
          unique case (cmd)
            ixs_pkg::OP_PUSH_B: next_wbuf = {operand[7:0], 8'h00, 32'h0000_0000}; // RQ18
            ixs_pkg::OP_PUSH_W: next_wbuf = {operand[15:0], 32'h0000_0000};
            ixs_pkg::OP_PUSH_L: next_wbuf = {operand, 16'h0000};
            ixs_pkg::OP_CALL:   next_wbuf = {pc, 16'h0000};             // RQ15
            ixs_pkg::OP_TRAP:   next_wbuf = {status_word, pc};          // RQ16
            default:            next_wbuf = wbuf;
          endcase
          if (cmd <= ixs_pkg::OP_PUSH_L || cmd == ixs_pkg::OP_CALL ||
              cmd == ixs_pkg::OP_TRAP) begin
            // Decrement first, then write upward from the new top
            sp_new = sp_now - op_bytes(cmd);                            // RQ11 RQ12 RQ13
            if (next_use_priv) next_privileged_stack_pointer = sp_new;
            else               next_unprivileged_stack_pointer = sp_new;
            next_cur_addr = sp_new;
            next_state = ST_PUSH;
          end else begin
            // Read from the current top; the pointer moves when done
            next_cur_addr = sp_now;                                     // RQ12 RQ14
            next_rbuf = 32'h0000_0000;
            next_state = ST_POP_REQ;
          end
        end
      end
      ST_PUSH: begin
        mem_req.en    = 1'b1;
        mem_req.we    = 1'b1;
        mem_req.addr  = cur_addr;
        mem_req.wdata = wbuf[47:32];
        mem_req.lanes = (op == ixs_pkg::OP_PUSH_B) ? ixs_pkg::LANES_HIGH   // RQ18
                                                   : ixs_pkg::LANES_ALL;
        next_cur_addr = cur_addr + ixs_pkg::BYTES_WORD;                 // RQ17
        next_wbuf = {wbuf[31:0], 16'h0000};
        next_words_left = words_left - 2'h1;
        if (words_left == 2'h0) begin
          next_state = ST_IDLE;
          if (op == ixs_pkg::OP_CALL) next_pc = operand;                // RQ15
          if (op == ixs_pkg::OP_TRAP) begin
            next_pc = operand;                                          // RQ16
            next_status_word[ixs_pkg::SW_PRIV] = 1'b1;
          end
        end
      end
      ST_POP_REQ: begin
        mem_req.en    = 1'b1;
        mem_req.addr  = cur_addr;
        mem_req.lanes = ixs_pkg::LANES_ALL;
        next_state = ST_POP_DATA;
      end
      ST_POP_DATA: begin
        pulled = {rbuf[15:0], mem_rdata};
        next_rbuf = pulled;
        next_cur_addr = cur_addr + ixs_pkg::BYTES_WORD;
        next_words_left = words_left - 2'h1;
        next_state = ST_POP_REQ;
        if (words_left == 2'h0) begin
          next_state = ST_IDLE;
          // Pointer rises only after the last word is read
          sp_now = use_priv ? privileged_stack_pointer : unprivileged_stack_pointer;
          sp_new = sp_now + op_bytes(op);                               // RQ14 RQ17
          if (use_priv) next_privileged_stack_pointer = sp_new;
          else          next_unprivileged_stack_pointer = sp_new;
          unique case (op)
            ixs_pkg::OP_POP_B: next_result = {24'h00_0000, mem_rdata[15:8]}; // RQ18
            ixs_pkg::OP_POP_W: next_result = {16'h0000, mem_rdata};
            ixs_pkg::OP_RET:   next_pc = pulled;                        // RQ15
            default:           next_result = pulled;
          endcase
        end
      end
    endcase
    next_engine_busy = next_state != ST_IDLE;
  end
  // Register stage for all state, bus answer included
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) dreg[i] <= 32'h0000_0000;
      for (int i = 0; i < 7; i++) areg[i] <= 32'h0000_0000;
      status_word <= ixs_pkg::SW_RESET;
      {base, privileged_stack_pointer, unprivileged_stack_pointer, pc} <= '0;
      {operand, result, ea, index_scaled, cur_addr, rbuf, wbuf} <= '0;
      {ext_word, words_left, use_priv, engine_busy, wb_ack_o, wb_dat_o} <= '0;
      state <= ST_IDLE;
      op <= ixs_pkg::OP_PUSH_B;
    end else begin
      dreg <= next_dreg;
      areg <= next_areg;
      {status_word, ext_word, base, pc} <= {next_status_word, next_ext_word, next_base, next_pc};
      {operand, result, ea} <= {next_operand, next_result, next_ea};
      {cur_addr, wbuf, rbuf} <= {next_cur_addr, next_wbuf, next_rbuf};
      {words_left, use_priv, engine_busy} <= {next_words_left, next_use_priv, next_engine_busy};
      {wb_ack_o, wb_dat_o} <= {next_wb_ack_o, next_wb_dat_o};
      index_scaled <= next_index_scaled;
      privileged_stack_pointer <= next_privileged_stack_pointer;
      unprivileged_stack_pointer <= next_unprivileged_stack_pointer;
      state <= next_state;
      op <= next_op;
    end
  end

  // Read mux and acknowledge; a command write while busy waits for idle
  always_comb begin
    next_wb_ack_o = take;
    next_wb_dat_o = 32'h0000_0000;
    if (take && !wb_we_i) begin
      unique case (wb_adr_i)
        ixs_pkg::OFS_STATUS:  next_wb_dat_o = {16'h0000, status_word};
        ixs_pkg::OFS_EXT:     next_wb_dat_o = {16'h0000, ext_word};
        ixs_pkg::OFS_BASE:    next_wb_dat_o = base;
        ixs_pkg::OFS_EA:      next_wb_dat_o = ea;
        ixs_pkg::OFS_FIELDS:  next_wb_dat_o = {16'h0000, ext};
        ixs_pkg::OFS_INDEX:   next_wb_dat_o = index_scaled;
        ixs_pkg::OFS_PRIV_SP: next_wb_dat_o = privileged_stack_pointer;
        ixs_pkg::OFS_UPRV_SP: next_wb_dat_o = unprivileged_stack_pointer;
        ixs_pkg::OFS_ACT_SP:  next_wb_dat_o = active_stack_pointer;
        ixs_pkg::OFS_CMD:     next_wb_dat_o = {31'h0000_0000, engine_busy};
        ixs_pkg::OFS_OPERAND: next_wb_dat_o = result;
        ixs_pkg::OFS_PC:      next_wb_dat_o = pc;
        default: begin
          if ((wb_adr_i & ixs_pkg::BANK_MASK) == ixs_pkg::OFS_DREG) begin
            next_wb_dat_o = dreg[wb_adr_i[4:2]];
          end else if ((wb_adr_i & ixs_pkg::BANK_MASK) == ixs_pkg::OFS_AREG) begin
            next_wb_dat_o = (wb_adr_i[4:2] == ixs_pkg::SP_NUM) ? active_stack_pointer
                                                                : areg[wb_adr_i[4:2]];
          end
        end
      endcase
    end
  end

  // Stack memory
  ixs_stack_mem #(
    .AW (MEM_AW)
  ) u_mem (
    .ref_clk (ref_clk),
    .req     (mem_req),
    .rdata   (mem_rdata)
  );

endmodule

// file: ixs_wb_host.sv
// Purpose: Classic Wishbone host that stands on the register side of the block
// Assumes: One request at a time, full byte selects
// Notes:   Waits for ack without limit; the bench watchdog ends a hang
`timescale 1ns/1ps
module ixs_wb_host (
  input  wire logic        ref_clk,           // Clock
  input  wire logic        wb_ack_o,          // Slave acknowledge
  input  wire logic [31:0] wb_dat_o,          // Slave read data
  output logic             wb_cyc_i = 1'b0,   // Cycle
  output logic             wb_stb_i = 1'b0,   // Strobe
  output logic             wb_we_i  = 1'b0,   // Write enable
  output logic [7:0]       wb_adr_i = 8'h00,  // Byte address
  output logic [3:0]       wb_sel_i = 4'hF,   // Byte selects
  output logic [31:0]      wb_dat_i = 32'h0   // Write data
);
  // One single cycle; request held until ack is seen, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
endmodule

// file: ixs_decode_stack_sva.sv
// Purpose: Port-level checks of bus timing and stack engine schedule
// Assumes: Sees only the top ports
// Notes:   Busy lengths are the engine's per-op schedule
`timescale 1ns/1ps
module ixs_chk (
  input wire logic        ref_clk,      // Clock
  input wire logic        srst,         // Reset
  input wire logic        wb_cyc_i,     // Cycle
  input wire logic        wb_stb_i,     // Strobe
  input wire logic        wb_we_i,      // Write enable
  input wire logic [7:0]  wb_adr_i,     // Address
  input wire logic [31:0] wb_dat_i,     // Write data
  input wire logic        wb_ack_o,     // Ack
  input wire logic        engine_busy,  // Busy
  input wire logic        supervisor    // Privilege
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic       take;
  logic       cmdw;
  logic [3:0] op;
  // A command is taken only on an idle engine
  assign cmdw = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h24;
  assign take = cmdw && !engine_busy && !wb_ack_o;
  assign op   = wb_dat_i[3:0];
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !(cmdw && engine_busy)
    |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one cycle after request");
  a_push_short: assert property (take && op < 4'h2 |=> engine_busy ##1 !engine_busy)
    else $error("short push busy length wrong");
  a_push_long: assert property (take && (op == 4'h2 || op == 4'h6)
    |=> engine_busy[*2] ##1 !engine_busy) else $error("long push busy length wrong");
  a_pop_short: assert property (take && (op == 4'h3 || op == 4'h4)
    |=> engine_busy[*2] ##1 !engine_busy) else $error("short pop busy length wrong");
  a_pop_long: assert property (take && (op == 4'h5 || op == 4'h7)
    |=> engine_busy[*4] ##1 !engine_busy) else $error("long pop busy length wrong");
  a_trap_len: assert property (take && op == 4'h8 |=> engine_busy[*3] ##1 !engine_busy)
    else $error("trap busy length wrong");
  a_trap_priv: assert property (take && op == 4'h8 |-> ##[1:4] supervisor)
    else $error("trap left user state");
  a_sup_reset: assert property (disable iff (1'b0) srst |=> supervisor)
    else $error("reset not supervisor");
  a_sup_cause: assert property ($changed(supervisor) |-> wb_ack_o || $past(engine_busy))
    else $error("privilege changed without cause");
endmodule
bind ixs_decode_stack ixs_chk u_chk (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .engine_busy(engine_busy), .supervisor(supervisor));

// file: ixs_decode_stack_test.sv
// Purpose: Self-checking bench for index decode and stack engine
// Assumes: Expected values worked out by hand from the field layout
// Notes:   Stack memory is not reset, so every pop reads a slot pushed first
`timescale 1ns/1ps
module ixs_decode_stack_test;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic        cyc, stb, we, ack, busy, sup;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, d;
  int          mismatches = 0;
  int          cmp_count  = 0;
  ixs_wb_host host (.ref_clk(ref_clk), .wb_ack_o(ack), .wb_dat_o(rdat), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat));
  ixs_decode_stack #(.MEM_AW(10)) dut (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .engine_busy(busy), .supervisor(sup));
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    host.xfer(1'b0, a, 32'h0, d);
    chk(nm, d, exp);
  endtask
  // Operand, then command; wait for idle, the watchdog ends a hang
  task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
    wr(8'h28, arg);
    wr(8'h24, {28'h0, op});
    do @(posedge ref_clk); while (busy !== 1'b0);
  endtask
  // Four extension words covering both kinds, both sizes, every scale code
  task automatic t_index;
    logic [15:0] ext [4] = '{16'h34FE, 16'h3E00, 16'hAA04, 16'h3000};
    logic [31:0] idx [4] = '{32'hFFFE_0000, 32'h000C_0000, 32'h20, 32'hFFFF_8000};
    logic [31:0] ea  [4] = '{32'hFFFE_0FFE, 32'h000C_1000, 32'h1024, 32'hFFFF_9000};
    wr(8'h08, 32'h1000);
    wr(8'h4C, 32'h0001_8000);
    wr(8'h68, 32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, {16'h0, ext[i]});
      rc(8'h10, {16'h0, ext[i]}, "fields");
      rc(8'h14, idx[i], "index");
      rc(8'h0C, ea[i], "ea");
    end
    rc(8'h4C, 32'h0001_8000, "dreg3");
  endtask
  task automatic t_stack;
    wr(8'h18, 32'h100);
    cmd(4'h1, 32'h5678);
    rc(8'h20, 32'hFE, "sp_push");
    cmd(4'h3, 32'h0);
    rc(8'h28, 32'h56, "pop_b");
    rc(8'h18, 32'h100, "sp_pop");
    cmd(4'h0, 32'h9A);
    cmd(4'h4, 32'h0);
    rc(8'h28, 32'h9A78, "pop_w");
    cmd(4'h2, 32'h1122_3344);
    rc(8'h20, 32'hFC, "sp_long");
    wr(8'h28, 32'h0);
    wr(8'h24, 32'h5);
    rc(8'h24, 32'h1, "busy");
    rc(8'h28, 32'h1122_3344, "pop_l");
  endtask
  task automatic t_calls;
    wr(8'h00, 32'h1);
    wr(8'h7C, 32'h200);
    wr(8'h2C, 32'h4000);
    chk("user", {31'h0, sup}, 32'h0);
    rc(8'h7C, 32'h200, "a7_user");
    cmd(4'h6, 32'h5000);
    rc(8'h1C, 32'h1FC, "call_sp");
    rc(8'h18, 32'h100, "ssp_kept");
    cmd(4'h7, 32'h0);
    rc(8'h2C, 32'h4000, "ret_pc");
    cmd(4'h8, 32'h6000);
    rc(8'h18, 32'hFA, "trap_sp");
    rc(8'h20, 32'hFA, "act_sup");
    cmd(4'h4, 32'h0);
    rc(8'h28, 32'h1, "frame_sw");
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well past the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    rc(8'h00, 32'h2000, "status_rst");
    rc(8'h30, 32'h0, "unmapped");
    t_index();
    t_stack();
    t_calls();
    give_verdict();
  end
endmodule
